// File: design/scb_bus_master.sv
// Synchronous 32-bit bus master: start strobe, acknowledge handling, bursts, time-out.
// Assumes peripheral pins are synchronous to MCLK; wire levels are resolved outside.
`timescale 1ns/1ps
module scb_bus_master
	import scb_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEF
)(
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// Request side
	input wire logic REQ_VALID,
	input wire scb_req_t REQ,
	output logic REQ_READY,
	// Completion side
	output logic DONE,
	output logic DONE_ERR,
	output logic DONE_LAST,
	output logic [31:0] DONE_RDATA,
	// Chip-select setup
	input wire scb_cs_cfg_t [NUM_CS-1:0] CS_CFG,
	// Address phase pins
	output logic [0:31] BUS_ADDR,
	output logic TRANSFER_START_STROBE_N,
	output logic [0:1] TRANSFER_SIZE,
	output logic BUS_RD_WR,
	output logic [0:3] ADDRESS_TYPE,
	output logic BURST_DATA_IN_PROGRESS_N,
	// Data pins
	input wire logic [0:31] BUS_DATA_I,
	output logic [0:31] BUS_DATA_O,
	output logic BUS_DATA_OE,
	// Termination pins
	input wire logic TRANSFER_ACK_N,
	input wire logic TRANSFER_ERROR_ACK_N_I,
	output logic TRANSFER_ERROR_ACK_N_O,
	output logic TRANSFER_ERROR_ACK_OE,
	input wire logic BURST_REFUSE_N_I,
	output logic BURST_REFUSE_N_O,
	output logic BURST_REFUSE_OE,
	// Chip-select pins
	output logic [NUM_CS-1:0] CS_N,
	output logic WE_N,
	output logic OE_N,
	// Status
	output logic BUSY
);
	localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);
	localparam logic [TO_W-1:0] TO_LIMIT = TO_W'(TIMEOUT_CYCLES - 1);

	scb_state_t state_q;
	scb_req_t req_q;
	logic [1:0] beat_q;
	logic [1:0] left_q;
	logic burst_q;
	logic own_refuse_q;
	logic [TO_W-1:0] to_cnt_q;
	logic last_valid_q;
	logic [2:0] last_sel_q;
	logic launch_w;
	logic beat_w;
	logic finish_w;
	logic timer_ack_w;
	logic ack_w;
	logic err_w;
	logic timeout_w;
	logic refuse_w;
	logic hit_w;
	logic [2:0] sel_w;
	logic first_w;
	scb_req_t next_w;
	logic [31:0] step_addr_w;

	// ****************************************
	// Helpers
	// ****************************************
	// Lowest matching chip select wins
	function automatic logic [3:0] cs_decode(input logic [31:0] a,
		input scb_cs_cfg_t [NUM_CS-1:0] c);
		logic [3:0] r;
		r = 4'h0;
		for (int i = NUM_CS - 1; i >= 0; i--) begin
			if (c[i].valid && ((a & c[i].mask) == (c[i].base & c[i].mask))) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction

	// Place write data on the top lanes
	function automatic logic [31:0] lane_put(input logic [1:0] s, input logic [31:0] d);
		case (s)
			TSIZ_HALF: return {d[15:0], 16'h0};
			TSIZ_BYTE: return {d[7:0], 24'h0};
			default: return d;
		endcase
	endfunction

	// Take read data from the top lanes
	function automatic logic [31:0] lane_get(input logic [1:0] s, input logic [31:0] d);
		case (s)
			TSIZ_HALF: return {16'h0, d[31:16]};
			TSIZ_BYTE: return {24'h0, d[31:24]};
			default: return d;
		endcase
	endfunction

	// ****************************************
	// Launch decision
	// ****************************************
	// Recovery relaunches reuse the stored request with the next word address, wrapping inside the 16-byte line
	assign step_addr_w = {req_q.addr[31:4], req_q.addr[3:2] + WORD_STEP, 2'b00};
	always_comb begin
		next_w = REQ;
		if (state_q == ST_RECOVER) begin
			next_w = req_q;
			next_w.addr = step_addr_w;
			next_w.burst = 1'b0;
		end
		if (next_w.burst) begin
			next_w.addr[1:0] = 2'b00;
			next_w.size = TSIZ_WORD;
		end
	end

	assign {hit_w, sel_w} = cs_decode(next_w.addr, CS_CFG);
	assign first_w = !last_valid_q || last_sel_q != sel_w;
	assign launch_w = (state_q == ST_IDLE && REQ_VALID && REQ_READY)
		|| (state_q == ST_RECOVER && TRANSFER_ACK_N && TRANSFER_ERROR_ACK_N_I
		&& left_q != 2'h0);

	// ****************************************
	// Termination decode
	// ****************************************
	// Peripheral acknowledge, or the generator's own
	assign ack_w = !TRANSFER_ACK_N || timer_ack_w;
	assign timeout_w = to_cnt_q == TO_LIMIT;
	assign err_w = !TRANSFER_ERROR_ACK_N_I || timeout_w;
	assign refuse_w = !BURST_REFUSE_N_I || own_refuse_q;
	assign finish_w = state_q == ST_DATA && (err_w || (ack_w && !(burst_q && !refuse_w
		&& beat_q != LAST_BEAT)));
	assign beat_w = state_q == ST_DATA && !err_w && ack_w && burst_q && !refuse_w
		&& beat_q != LAST_BEAT;

	// ****************************************
	// Sequencer
	// ****************************************
	// Everything on the rising edge
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			state_q <= ST_IDLE;
			req_q <= '0;
			beat_q <= 2'h0;
			left_q <= 2'h0;
			burst_q <= 1'b0;
			REQ_READY <= 1'b1;
			BUSY <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE, ST_RECOVER: begin
					if (launch_w) begin
						req_q <= next_w;
						burst_q <= next_w.burst;
						if (state_q == ST_IDLE) begin
							beat_q <= 2'h0;
							left_q <= 2'h0;
						end else begin
							left_q <= left_q - 2'h1;
						end
						REQ_READY <= 1'b0;
						BUSY <= 1'b1;
						state_q <= ST_START;
					end else if (state_q == ST_RECOVER && TRANSFER_ACK_N
						&& TRANSFER_ERROR_ACK_N_I) begin
						REQ_READY <= 1'b1;
						BUSY <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
				ST_START: state_q <= ST_DATA;
				ST_DATA: begin
					if (err_w) begin
						left_q <= 2'h0;
						state_q <= ST_RECOVER;
					end else if (ack_w) begin
						beat_q <= beat_q + 2'h1;
						if (!beat_w) begin
							// Refused burst falls back to singles
							if (burst_q) begin
								left_q <= LAST_BEAT - beat_q;
							end
							burst_q <= 1'b0;
							state_q <= ST_RECOVER;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// Address phase and data pins
	// ****************************************
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			BUS_ADDR <= ADDR_RESET;
			TRANSFER_START_STROBE_N <= 1'b1;
			TRANSFER_SIZE <= TSIZ_WORD;
			BUS_RD_WR <= 1'b1;
			ADDRESS_TYPE <= 4'h0;
			BURST_DATA_IN_PROGRESS_N <= 1'b1;
			BUS_DATA_O <= 32'h0;
			BUS_DATA_OE <= 1'b0;
		end else if (launch_w) begin
			// Port bit zero is the top address bit
			BUS_ADDR <= next_w.addr;
			TRANSFER_START_STROBE_N <= 1'b0;
			TRANSFER_SIZE <= next_w.size;
			BUS_RD_WR <= next_w.read;
			ADDRESS_TYPE <= next_w.atype;
			BURST_DATA_IN_PROGRESS_N <= !next_w.burst;
			BUS_DATA_O <= lane_put(next_w.size, next_w.wdata);
			BUS_DATA_OE <= !next_w.read;
		end else begin
			TRANSFER_START_STROBE_N <= 1'b1;
			if (beat_w && beat_q == LAST_BEAT - 2'h1) begin
				BURST_DATA_IN_PROGRESS_N <= 1'b1;
			end
			if (finish_w) begin
				BURST_DATA_IN_PROGRESS_N <= 1'b1;
				BUS_DATA_OE <= 1'b0;
			end
		end
	end

	// ****************************************
	// Completion report
	// ****************************************
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			DONE <= 1'b0;
			DONE_ERR <= 1'b0;
			DONE_LAST <= 1'b0;
			DONE_RDATA <= 32'h0;
		end else begin
			DONE <= state_q == ST_DATA && (err_w || ack_w);
			DONE_ERR <= state_q == ST_DATA && err_w;
			DONE_LAST <= finish_w && (err_w || left_q == 2'h0)
				&& !(burst_q && beat_q != LAST_BEAT);
			if (state_q == ST_DATA && ack_w && !err_w && req_q.read) begin
				DONE_RDATA <= lane_get(req_q.size, BUS_DATA_I);
			end
		end
	end

	// ****************************************
	// Time-out and error drive
	// ****************************************
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			to_cnt_q <= '0;
			TRANSFER_ERROR_ACK_N_O <= 1'b1;
			TRANSFER_ERROR_ACK_OE <= 1'b0;
		end else begin
			if (state_q != ST_DATA || beat_w) begin
				to_cnt_q <= '0;
			end else begin
				to_cnt_q <= to_cnt_q + TO_W'(1);
			end
			TRANSFER_ERROR_ACK_N_O <= !(state_q == ST_DATA && timeout_w);
			TRANSFER_ERROR_ACK_OE <= state_q == ST_DATA && timeout_w;
		end
	end

	// ****************************************
	// Burst refuse and chip-select history
	// ****************************************
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			own_refuse_q <= 1'b0;
			BURST_REFUSE_N_O <= 1'b1;
			BURST_REFUSE_OE <= 1'b0;
			last_valid_q <= 1'b0;
			last_sel_q <= 3'h0;
		end else if (launch_w) begin
			own_refuse_q <= next_w.burst && hit_w && CS_CFG[sel_w].auto_refuse;
			BURST_REFUSE_N_O <= !(next_w.burst && hit_w && CS_CFG[sel_w].auto_refuse);
			BURST_REFUSE_OE <= next_w.burst && hit_w && CS_CFG[sel_w].auto_refuse;
			last_valid_q <= hit_w;
			last_sel_q <= sel_w;
		end else if (finish_w) begin
			own_refuse_q <= 1'b0;
			BURST_REFUSE_N_O <= 1'b1;
			BURST_REFUSE_OE <= 1'b0;
		end
	end

	scb_cs_timer u_timer (
		.clk(MCLK),
		.rst(RESET),
		.launch(launch_w),
		.beat(beat_w),
		.finish(finish_w),
		.hit(hit_w),
		.sel(sel_w),
		.first_access(first_w),
		.read(next_w.read),
		.cfg(CS_CFG[sel_w]),
		.cs_n_o(CS_N),
		.we_n_o(WE_N),
		.oe_n_o(OE_N),
		.int_ack_o(timer_ack_w)
	);

	// ****************************************
	// Checks
	// ****************************************
	sequence s_tea_pulse;
		TRANSFER_ERROR_ACK_OE ##1 !TRANSFER_ERROR_ACK_OE;
	endsequence
	sequence s_strobe;
		!TRANSFER_START_STROBE_N ##1 TRANSFER_START_STROBE_N;
	endsequence

	AST_STROBE_ONE_CLOCK: assert property (@(posedge MCLK) disable iff (RESET)
		$fell(TRANSFER_START_STROBE_N) |-> s_strobe)
		else $error("start strobe not exactly one clock");
	AST_MIN_TWO_CLOCKS: assert property (@(posedge MCLK) disable iff (RESET)
		!TRANSFER_START_STROBE_N |-> ##1 !DONE)
		else $error("transaction finished in under two clocks");
	AST_ACK_RELEASE: assert property (@(posedge MCLK) disable iff (RESET)
		(state_q == ST_RECOVER && !TRANSFER_ACK_N) |=> TRANSFER_START_STROBE_N)
		else $error("new cycle launched while acknowledge held");
	AST_BURST_ALIGNED: assert property (@(posedge MCLK) disable iff (RESET)
		(!TRANSFER_START_STROBE_N && !BURST_DATA_IN_PROGRESS_N)
		|-> (BUS_ADDR[30:31] == 2'b00 && TRANSFER_SIZE == TSIZ_WORD))
		else $error("burst not aligned 32-bit");
	AST_DIR_HELD: assert property (@(posedge MCLK) disable iff (RESET)
		(state_q == ST_DATA) |-> ($stable(BUS_RD_WR) && $stable(BUS_ADDR)))
		else $error("direction or address moved during transfer");
	AST_TIMEOUT_ERROR: assert property (@(posedge MCLK) disable iff (RESET)
		(state_q == ST_DATA && to_cnt_q == TO_LIMIT) |=> s_tea_pulse)
		else $error("time-out did not pulse error acknowledge");
	AST_ERROR_ABORT: assert property (@(posedge MCLK) disable iff (RESET)
		(state_q == ST_DATA && !TRANSFER_ERROR_ACK_N_I)
		|=> (DONE && DONE_ERR && state_q == ST_RECOVER && left_q == 2'h0))
		else $error("error acknowledge did not abort");
	AST_REFUSE_REVERT: assert property (@(posedge MCLK) disable iff (RESET)
		(state_q == ST_DATA && burst_q && ack_w && refuse_w && !err_w
		&& beat_q != LAST_BEAT) |=> (BURST_DATA_IN_PROGRESS_N && left_q != 2'h0))
		else $error("refused burst not converted to singles");
	AST_AUTO_REFUSE: assert property (@(posedge MCLK) disable iff (RESET)
		(launch_w && next_w.burst && hit_w && CS_CFG[sel_w].auto_refuse)
		|=> (BURST_REFUSE_OE && !BURST_REFUSE_N_O))
		else $error("region did not refuse burst");
	AST_HALF_LANES: assert property (@(posedge MCLK) disable iff (RESET)
		(!TRANSFER_START_STROBE_N && !BUS_RD_WR && TRANSFER_SIZE == TSIZ_HALF)
		|-> (BUS_DATA_O[16:31] == 16'h0))
		else $error("halfword write off the top lanes");
endmodule

// File: design/scb_pkg.sv
// Constants and carriers for the synchronous bus master and its chip-select timer.
// Assumes a single clock; every bus pin is sampled or driven on its rising edge.
package scb_pkg;
	// ****************************************
	// Sizes and encodings
	// ****************************************
	localparam int NUM_CS = 8;
	localparam int BURST_BEATS = 4;
	localparam int MIN_BUS_CLOCKS = 2;
	localparam int MAX_WAIT_STATES = 15;
	localparam int TIMEOUT_CYCLES_DEF = 256;
	localparam logic [1:0] TSIZ_WORD = 2'h0;
	localparam logic [1:0] TSIZ_BYTE = 2'h1;
	localparam logic [1:0] TSIZ_HALF = 2'h2;
	localparam logic [1:0] ACS_NONE = 2'h0;
	localparam logic [1:0] ACS_QUARTER = 2'h1;
	localparam logic [1:0] ACS_HALF = 2'h2;
	localparam logic [1:0] LAST_BEAT = 2'h3;
	localparam logic [1:0] WORD_STEP = 2'h1;
	localparam logic [4:0] CNT_MAX = 5'h1f;
	localparam logic [31:0] ADDR_RESET = 32'h0;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [31:0] base;
		logic [31:0] mask;
		logic valid;
		logic use_pattern;
		logic [1:0] assert_delay;
		logic early_negate;
		logic relaxed;
		logic ext_hold;
		logic [3:0] wait_states;
		logic internal_ack;
		logic auto_refuse;
	} scb_cs_cfg_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [1:0] size;
		logic read;
		logic [3:0] atype;
		logic burst;
		logic [31:0] wdata;
	} scb_req_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_DATA = 2'b10,
		ST_RECOVER = 2'b11
	} scb_state_t;
endpackage

// File: design/scb_cs_timer.sv
// General chip-select timer: one active chip select, setup delay, wait states, early release.
// Assumes launch comes one clock before the start strobe and finish on the ending edge.
`timescale 1ns/1ps
module scb_cs_timer
	import scb_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control from the bus sequencer
	input wire logic launch,
	input wire logic beat,
	input wire logic finish,
	input wire logic hit,
	input wire logic [2:0] sel,
	input wire logic first_access,
	input wire logic read,
	input wire scb_cs_cfg_t cfg,
	// Pins and internal acknowledge
	output logic [NUM_CS-1:0] cs_n_o,
	output logic we_n_o,
	output logic oe_n_o,
	output logic int_ack_o
);
	scb_cs_cfg_t cfg_q;
	logic active_q;
	logic en_q;
	logic read_q;
	logic [2:0] sel_q;
	logic [4:0] cnt_q;
	logic [4:0] setup_q;
	logic [4:0] setup_w;
	logic [4:0] last_w;
	logic [4:0] next_w;
	logic on_w;

	function automatic logic [4:0] last_of(input logic [4:0] s, input logic [3:0] w);
		logic [4:0] t;
		t = s + {1'b0, w};
		return (t == 5'h0) ? 5'h1 : t;
	endfunction

	assign setup_w = {4'h0, cfg.assert_delay != ACS_NONE} + {4'h0, cfg.relaxed}
		+ {4'h0, cfg.ext_hold & first_access};
	assign last_w = last_of(setup_q, cfg_q.wait_states);
	assign next_w = (cnt_q == CNT_MAX) ? CNT_MAX : cnt_q + 5'h1;
	assign on_w = (next_w >= setup_q) && !(cfg_q.early_negate && cfg_q.internal_ack
		&& next_w >= last_w);

	// ****************************************
	// Timing state
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_q <= '0;
			active_q <= 1'b0;
			en_q <= 1'b0;
			read_q <= 1'b0;
			sel_q <= 3'h0;
			cnt_q <= 5'h0;
			setup_q <= 5'h0;
		end else if (launch) begin
			cfg_q <= cfg;
			active_q <= 1'b1;
			en_q <= hit && cfg.valid && !cfg.use_pattern;
			read_q <= read;
			sel_q <= sel;
			cnt_q <= 5'h0;
			setup_q <= setup_w;
		end else if (finish) begin
			active_q <= 1'b0;
			cnt_q <= 5'h0;
		end else if (beat) begin
			cnt_q <= 5'h0;
			setup_q <= 5'h0;
		end else if (active_q) begin
			cnt_q <= next_w;
		end
	end

	// ****************************************
	// Pin drive
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			cs_n_o <= '1;
			we_n_o <= 1'b1;
			oe_n_o <= 1'b1;
			int_ack_o <= 1'b0;
		end else if (launch) begin
			cs_n_o <= '1;
			if (hit && cfg.valid && !cfg.use_pattern && setup_w == 5'h0) begin
				cs_n_o[sel] <= 1'b0;
			end
			we_n_o <= !(hit && cfg.valid && !cfg.use_pattern && setup_w == 5'h0 && !read);
			oe_n_o <= !(hit && cfg.valid && !cfg.use_pattern && setup_w == 5'h0 && read);
			int_ack_o <= 1'b0;
		end else if (finish || !active_q) begin
			cs_n_o <= '1;
			we_n_o <= 1'b1;
			oe_n_o <= 1'b1;
			int_ack_o <= 1'b0;
		end else begin
			cs_n_o <= '1;
			cs_n_o[sel_q] <= !(en_q && (beat || on_w));
			we_n_o <= !(en_q && (beat || on_w) && !read_q);
			oe_n_o <= !(en_q && (beat || on_w) && read_q);
			int_ack_o <= en_q && cfg_q.internal_ack && !beat
				&& next_w == last_w;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	AST_CS_AFTER_SETUP: assert property (@(posedge clk) disable iff (rst)
		(active_q && cs_n_o != '1) |-> (cnt_q >= setup_q))
		else $error("chip select asserted before its setup delay");
	AST_WAIT_COUNT: assert property (@(posedge clk) disable iff (rst)
		int_ack_o |-> (cnt_q == last_w && cnt_q >= 5'h1))
		else $error("internal acknowledge off its wait-state count");
endmodule

// File: tb/scb_periph_model.sv
// Peripheral model facing the bus master: acknowledge, error and burst refuse.
// Assumes the bench resolves open-drain lines with pull-ups.
`timescale 1ns/1ps
module scb_periph_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bus from master
	input wire logic strobe_n,
	input wire logic [0:31] addr,
	input wire logic burst_data_in_progress_n,
	// Behaviour controls
	input wire logic [3:0] delay,
	input wire logic refuse,
	input wire logic err,
	input wire logic mute,
	// Replies
	output logic ack_n,
	output logic tea_n,
	output logic bi_n,
	output logic [0:31] data_o
);
	logic busy_q;
	logic burst_q;
	logic [3:0] cnt_q;
	logic [1:0] beat_q;
	logic [31:0] base_q;

	always_ff @(posedge clk) begin
		ack_n <= 1'b1;
		tea_n <= 1'b1;
		bi_n <= 1'b1;
		// Released data never shows the last value
		data_o <= ~data_o;
		if (rst) begin
			busy_q <= 1'b0;
			data_o <= 32'h0;
		end else if (!strobe_n && !mute) begin
			busy_q <= 1'b1;
			burst_q <= !burst_data_in_progress_n;
			cnt_q <= delay;
			beat_q <= 2'h0;
			base_q <= addr;
		end else if (busy_q && cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end else if (busy_q) begin
			if (err) begin
				tea_n <= 1'b0;
			end else begin
				ack_n <= 1'b0;
				// Word index wraps inside the line
				data_o <= {base_q[31:4], base_q[3:2] + beat_q, 2'h0} ^ 32'h5a5a0000;
				bi_n <= !(refuse && burst_q);
			end
			beat_q <= beat_q + 2'h1;
			busy_q <= burst_q && !refuse && !err && beat_q != 2'h3;
		end
	end
endmodule

// File: tb/scb_bus_master_test.sv
// Self-checking bench for the bus master and its chip-select timer.
// Assumes the peripheral model answers on the pins; no register bus.
`timescale 1ns/1ps
module scb_bus_master_test
	import scb_pkg::*;
;
	logic mclk, reset, req_valid, req_ready, done, done_err, done_last;
	scb_req_t req;
	scb_cs_cfg_t [NUM_CS-1:0] cs_cfg;
	logic [31:0] done_rdata, st_addr, wr_seen;
	logic [0:31] bus_addr, bus_data_o, m_data;
	logic stb_n, burst_data_in_progress_n, rd_wr, st_rw, tea_o, tea_oe, bi_o, bi_oe;
	logic m_ack_n, m_tea_n, m_bi_n, tea_w, bi_w, tea_drv, bi_drv;
	logic [0:1] tsize;
	logic [1:0] st_size;
	logic [0:3] atype;
	logic [3:0] st_at, m_delay;
	logic [NUM_CS-1:0] cs_n;
	logic m_refuse, m_err, m_mute;
	int bad_count, compares, cyc, k, strobes, cs_low, cs_first;

	// Open-drain lines with pull-ups
	assign tea_w = m_tea_n & (~tea_oe | tea_o);
	assign bi_w = m_bi_n & (~bi_oe | bi_o);

	// Time-out must outlast fifteen wait states plus setup
	scb_bus_master #(.TIMEOUT_CYCLES(32)) u_scb_bus_master (.MCLK(mclk), .RESET(reset),
		.REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready), .DONE(done),
		.DONE_ERR(done_err), .DONE_LAST(done_last), .DONE_RDATA(done_rdata),
		.CS_CFG(cs_cfg), .BUS_ADDR(bus_addr), .TRANSFER_START_STROBE_N(stb_n),
		.TRANSFER_SIZE(tsize), .BUS_RD_WR(rd_wr), .ADDRESS_TYPE(atype),
		.BURST_DATA_IN_PROGRESS_N(burst_data_in_progress_n), .BUS_DATA_I(m_data), .BUS_DATA_O(bus_data_o),
		.BUS_DATA_OE(), .TRANSFER_ACK_N(m_ack_n), .TRANSFER_ERROR_ACK_N_I(tea_w),
		.TRANSFER_ERROR_ACK_N_O(tea_o), .TRANSFER_ERROR_ACK_OE(tea_oe),
		.BURST_REFUSE_N_I(bi_w), .BURST_REFUSE_N_O(bi_o), .BURST_REFUSE_OE(bi_oe),
		.CS_N(cs_n), .WE_N(), .OE_N(), .BUSY());

	scb_periph_model u_scb_periph_model (.clk(mclk), .rst(reset), .strobe_n(stb_n),
		.addr(bus_addr), .burst_data_in_progress_n(burst_data_in_progress_n), .delay(m_delay), .refuse(m_refuse), .err(m_err),
		.mute(m_mute), .ack_n(m_ack_n), .tea_n(m_tea_n), .bi_n(m_bi_n), .data_o(m_data));

	// ****************************************
	// Monitor and reporting
	// ****************************************
	always @(posedge mclk) begin
		if (stb_n === 1'b0) begin
			k = 0;
			strobes++;
			st_addr = bus_addr;
			st_size = tsize;
			st_rw = rd_wr;
			st_at = atype;
		end else begin
			k++;
		end
		if (cs_n[0] === 1'b0) begin
			if (cs_low == 0) cs_first = k;
			cs_low++;
		end
		if (m_ack_n === 1'b0) wr_seen = bus_data_o;
		if (tea_oe === 1'b1 && tea_o === 1'b0) tea_drv = 1'b1;
		if (bi_oe === 1'b1 && bi_o === 1'b0) bi_drv = 1'b1;
		cyc++;
		// Whole run needs well under a thousand cycles
		if (cyc > 5000) begin
			bad_count++;
			stop_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ****************************************
	// Request and completion helpers
	// ****************************************
	task automatic issue(input logic [31:0] a, input logic [1:0] sz, input logic rd,
		input logic bu, input logic [31:0] wd);
		@(negedge mclk);
		req_valid = 1'b1;
		req = '{addr: a, size: sz, read: rd, atype: 4'h5, burst: bu, wdata: wd};
		while (req_ready !== 1'b1) @(negedge mclk);
		@(negedge mclk);
		req_valid = 1'b0;
	endtask

	task automatic wait_done(output int n);
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (done !== 1'b1 && n < 400);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_read();
		int n;
		strobes = 0;
		m_delay = 4'h2;
		issue(32'h00001234, TSIZ_WORD, 1'b1, 1'b0, 32'h0);
		wait_done(n);
		check(n >= 4, 1'b1);
		check(strobes, 1);
		check(st_addr, 32'h00001234);
		check(st_rw, 1'b1);
		check(st_at, 4'h5);
		check(done_rdata, 32'h5a5a1234);
		m_delay = 4'h0;
	endtask

	task automatic t_writes();
		int n;
		logic [1:0] sz [3] = '{TSIZ_BYTE, TSIZ_HALF, TSIZ_WORD};
		logic [31:0] msk [3] = '{32'hff000000, 32'hffff0000, 32'hffffffff};
		logic [31:0] exp [3] = '{32'hef000000, 32'hcdef0000, 32'h89abcdef};
		for (int i = 0; i < 3; i++) begin
			issue(32'h00002001, sz[i], 1'b0, 1'b0, 32'h89abcdef);
			wait_done(n);
			check(st_rw, 1'b0);
			check(st_size, sz[i]);
			check(wr_seen & msk[i], exp[i]);
		end
	endtask

	task automatic t_burst(input logic refuse, input int nstb);
		int n;
		m_refuse = refuse;
		strobes = 0;
		issue(32'h0000010a, TSIZ_HALF, 1'b1, 1'b1, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wait_done(n);
			if (i == 0) check(st_addr, 32'h00000108);
			if (i == 0) check(st_size, TSIZ_WORD);
			check(done_rdata, {28'h0000010, 2'(i + 2), 2'h0} ^ 32'h5a5a0000);
			check(done_last, i == 3);
		end
		check(strobes, nstb);
		m_refuse = 1'b0;
	endtask

	task automatic t_fault(input logic mute);
		int n;
		m_err = !mute;
		m_mute = mute;
		tea_drv = 1'b0;
		issue(32'h00003000, TSIZ_WORD, 1'b1, 1'b0, 32'h0);
		wait_done(n);
		check(done_err, 1'b1);
		check(done_last, 1'b1);
		// Master's own error drive starts with the abort; the monitor records it one clock later
		@(negedge mclk);
		check(tea_drv, mute);
		m_err = 1'b0;
		m_mute = 1'b0;
	endtask

	task automatic t_cs();
		int n, setup, ack;
		logic [1:0] ad [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
		logic [3:0] ws [5] = '{4'h3, 4'h2, 4'h5, 4'hf, 4'h0};
		logic rl [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
		logic en [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
		m_mute = 1'b1;
		for (int i = 0; i < 5; i++) begin
			// Only the first entry is a first access; later ones repeat CS0
			cs_cfg[0] = '{base: 32'h10000000, mask: 32'hffff0000, valid: 1'b1, use_pattern: 1'b0,
				assert_delay: ad[i], early_negate: en[i], relaxed: rl[i],
				ext_hold: (i == 0 || i >= 3),
				wait_states: ws[i], internal_ack: 1'b1, auto_refuse: 1'b0};
			setup = (ad[i] != 2'h0) + rl[i] + (i == 0);
			ack = (setup + ws[i] > 1) ? setup + ws[i] : 1;
			cs_low = 0;
			issue(32'h10000040, TSIZ_WORD, 1'b1, 1'b0, 32'h0);
			wait_done(n);
			check(cs_first, setup);
			check(cs_low, ack - setup + 1 - en[i]);
			check(done_err, 1'b0);
		end
		cs_cfg[0].auto_refuse = 1'b1;
		bi_drv = 1'b0;
		strobes = 0;
		issue(32'h10000040, TSIZ_WORD, 1'b1, 1'b1, 32'h0);
		for (int i = 0; i < 4; i++) wait_done(n);
		check(bi_drv, 1'b1);
		check(strobes, 4);
		cs_cfg = '0;
		m_mute = 1'b0;
	endtask

	// ****************************************
	// Clock and main sequence
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial begin
		reset = 1'b1;
		req_valid = 1'b0;
		req = '0;
		cs_cfg = '0;
		m_delay = 4'h0;
		m_refuse = 1'b0;
		m_err = 1'b0;
		m_mute = 1'b0;
		repeat (10) @(negedge mclk);
		reset = 1'b0;
		t_read();
		t_writes();
		t_burst(1'b0, 1);
		t_burst(1'b1, 4);
		t_fault(1'b0);
		t_fault(1'b1);
		t_cs();
		repeat (4) @(negedge mclk);
		stop_test();
	end
endmodule
